// ---- src/efcb_consts.vh ----
// constants for the channel b equalising fir coefficient bank
`ifndef EFCB_CONSTS_VH
`define EFCB_CONSTS_VH

// register word indices (not all multiples of four: byte address = 4 * index)
`define EFCB_IDX_TAP0       12'h448
`define EFCB_IDX_TAP1       12'h44A
`define EFCB_IDX_TAP2       12'h44C
`define EFCB_IDX_TAP3       12'h44E
`define EFCB_IDX_CENTER     12'h450
`define EFCB_IDX_STATUS     12'h460

// field layout
`define EFCB_OUTER_W        12
`define EFCB_OUTER_REG_W    16
`define EFCB_CENTER_W       18
`define EFCB_CENTER_REG_W   24

// reset values
`define EFCB_RST_OUTER      16'h0000
`define EFCB_RST_CENTER     24'h000000

// answer for an unmapped address
`define EFCB_UNMAPPED_DATA  32'h00000000

`endif

// ---- src/efcb_coeff_reg.v ----
// one coefficient register with masked readback of the field msb
`timescale 1ns/10ps
module efcb_coeff_reg #(
    parameter REG_W   = 16,
    parameter FIELD_W = 12
) (
    input  wire             mclk,
    input  wire             rstn,
    input  wire             wr_en,
    input  wire [REG_W-1:0] wr_data,
    output wire [REG_W-1:0] rd_data,
    output wire [REG_W-1:0] value
);
    reg [REG_W-1:0] val_q;

    always @(posedge mclk)
    begin
        if (!rstn)
            val_q <= {REG_W{1'b0}};
        else if (wr_en)
            val_q <= wr_data;
    end

    // readback hides the field msb; reserved bits read back as written
    assign rd_data = val_q & ~({{(REG_W-1){1'b0}}, 1'b1} << (FIELD_W - 1));
    assign value   = val_q;
endmodule // efcb_coeff_reg

// ---- src/efcb_bank.v ----
// channel b equalising fir coefficient bank, taps one to five, avalon-mm slave
//
// Function
// - outer taps one to four are 12-bit signed in bits 11:0, 15:12 reserved.
// - registers 0x448, 0x44A, 0x44C, 0x44E, 0x450 feed taps one to five.
// - channel b coefficients drive the filter only in dual-channel mode.
// - centre tap is 18-bit signed in bits 17:0, bits 23:18 reserved.
// - readback returns each coefficient field msb as zero.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "efcb_consts.vh"
module efcb_bank #(
    parameter ADDR_W = 14
) (
    input  wire                        mclk,
    input  wire                        rstn,
    input  wire [ADDR_W-1:0]           avs_address,
    input  wire                        avs_read,
    input  wire                        avs_write,
    input  wire [31:0]                 avs_writedata,
    input  wire [3:0]                  avs_byteenable,
    output reg  [31:0]                 avs_readdata,
    output reg                         avs_waitrequest,
    input  wire                        dual_channel_mode,
    output reg  [`EFCB_OUTER_W-1:0]    tap0_coeff,
    output reg  [`EFCB_OUTER_W-1:0]    tap1_coeff,
    output reg  [`EFCB_OUTER_W-1:0]    tap2_coeff,
    output reg  [`EFCB_OUTER_W-1:0]    tap3_coeff,
    output reg  [`EFCB_CENTER_W-1:0]   center_coeff,
    output reg                         coeff_valid
);
    localparam OW = `EFCB_OUTER_REG_W;
    localparam CW = `EFCB_CENTER_REG_W;

    // word index: byte address / 4
    wire [ADDR_W-3:0] idx = avs_address[ADDR_W-1:2];
    reg               ack_q;
    wire              req  = (avs_read | avs_write) & ~ack_q;

    // indices wider than the bus are cut to the index width before the compare
    function hit;
        input [ADDR_W-3:0] a;
        input [11:0]       i;
        begin
            hit = (a == i[ADDR_W-3:0]);
        end
    endfunction

    // byte enables merge with old contents
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1)
                if (be[k])
                    merge[k*8 +: 8] = nw[k*8 +: 8];
        end
    endfunction

    wire [4:0] sel;
    assign sel[0] = hit(idx, `EFCB_IDX_TAP0);
    assign sel[1] = hit(idx, `EFCB_IDX_TAP1);
    assign sel[2] = hit(idx, `EFCB_IDX_TAP2);
    assign sel[3] = hit(idx, `EFCB_IDX_TAP3);
    assign sel[4] = hit(idx, `EFCB_IDX_CENTER);
    wire sel_stat = hit(idx, `EFCB_IDX_STATUS);

    wire [OW-1:0] rd0;
    wire [OW-1:0] rd1;
    wire [OW-1:0] rd2;
    wire [OW-1:0] rd3;
    wire [CW-1:0] rd4;
    wire [OW-1:0] v0;
    wire [OW-1:0] v1;
    wire [OW-1:0] v2;
    wire [OW-1:0] v3;
    wire [CW-1:0] v4;

    // a write lands on the taking edge, the same edge that drops waitrequest
    wire [4:0]    wr_en = {5{req & avs_write}} & sel;

    // merged words are 32 bits; lanes above the register width are cut at the pin
    wire [31:0]   mrg0  = merge({16'h0000, v0}, avs_writedata, avs_byteenable);
    wire [31:0]   mrg1  = merge({16'h0000, v1}, avs_writedata, avs_byteenable);
    wire [31:0]   mrg2  = merge({16'h0000, v2}, avs_writedata, avs_byteenable);
    wire [31:0]   mrg3  = merge({16'h0000, v3}, avs_writedata, avs_byteenable);
    wire [31:0]   mrg4  = merge({8'h00, v4}, avs_writedata, avs_byteenable);

    efcb_coeff_reg #(
        .REG_W   (OW),
        .FIELD_W (`EFCB_OUTER_W)
    ) u_tap0 (
        .mclk    (mclk),
        .rstn    (rstn),
        .wr_en   (wr_en[0]),
        .wr_data (mrg0[OW-1:0]),
        .rd_data (rd0),
        .value   (v0)
    );

    efcb_coeff_reg #(
        .REG_W   (OW),
        .FIELD_W (`EFCB_OUTER_W)
    ) u_tap1 (
        .mclk    (mclk),
        .rstn    (rstn),
        .wr_en   (wr_en[1]),
        .wr_data (mrg1[OW-1:0]),
        .rd_data (rd1),
        .value   (v1)
    );

    efcb_coeff_reg #(
        .REG_W   (OW),
        .FIELD_W (`EFCB_OUTER_W)
    ) u_tap2 (
        .mclk    (mclk),
        .rstn    (rstn),
        .wr_en   (wr_en[2]),
        .wr_data (mrg2[OW-1:0]),
        .rd_data (rd2),
        .value   (v2)
    );

    efcb_coeff_reg #(
        .REG_W   (OW),
        .FIELD_W (`EFCB_OUTER_W)
    ) u_tap3 (
        .mclk    (mclk),
        .rstn    (rstn),
        .wr_en   (wr_en[3]),
        .wr_data (mrg3[OW-1:0]),
        .rd_data (rd3),
        .value   (v3)
    );

    efcb_coeff_reg #(
        .REG_W   (CW),
        .FIELD_W (`EFCB_CENTER_W)
    ) u_center (
        .mclk    (mclk),
        .rstn    (rstn),
        .wr_en   (wr_en[4]),
        .wr_data (mrg4[CW-1:0]),
        .rd_data (rd4),
        .value   (v4)
    );

    // status word is local: bit0 mode pin, bit1 taps live
    reg [31:0] rdata_d;
    always @*
    begin
        rdata_d = `EFCB_UNMAPPED_DATA;
        case (1'b1)
            sel[0]:   rdata_d = {16'h0000, rd0};
            sel[1]:   rdata_d = {16'h0000, rd1};
            sel[2]:   rdata_d = {16'h0000, rd2};
            sel[3]:   rdata_d = {16'h0000, rd3};
            sel[4]:   rdata_d = {8'h00, rd4};
            sel_stat: rdata_d = {30'h00000000, coeff_valid, dual_channel_mode};
            default:  rdata_d = `EFCB_UNMAPPED_DATA;
        endcase
    end

    // one wait cycle: request taken on first edge, answered on the second
    always @(posedge mclk)
    begin
        if (!rstn)
        begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end
        else
        begin
            ack_q           <= req;
            avs_waitrequest <= ~req;
            if (req & avs_read)
                avs_readdata <= rdata_d;
        end
    end

    // filter side: full stored value incl. sign bit; zero outside dual mode
    // sign bit reads back as zero, so software must keep its own copy
    always @(posedge mclk)
    begin
        if (!rstn)
        begin
            tap0_coeff   <= {`EFCB_OUTER_W{1'b0}};
            tap1_coeff   <= {`EFCB_OUTER_W{1'b0}};
            tap2_coeff   <= {`EFCB_OUTER_W{1'b0}};
            tap3_coeff   <= {`EFCB_OUTER_W{1'b0}};
            center_coeff <= {`EFCB_CENTER_W{1'b0}};
            coeff_valid  <= 1'b0;
        end
        else if (dual_channel_mode)
        begin
            tap0_coeff   <= v0[`EFCB_OUTER_W-1:0];
            tap1_coeff   <= v1[`EFCB_OUTER_W-1:0];
            tap2_coeff   <= v2[`EFCB_OUTER_W-1:0];
            tap3_coeff   <= v3[`EFCB_OUTER_W-1:0];
            center_coeff <= v4[`EFCB_CENTER_W-1:0];
            coeff_valid  <= 1'b1;
        end
        else
        begin
            tap0_coeff   <= {`EFCB_OUTER_W{1'b0}};
            tap1_coeff   <= {`EFCB_OUTER_W{1'b0}};
            tap2_coeff   <= {`EFCB_OUTER_W{1'b0}};
            tap3_coeff   <= {`EFCB_OUTER_W{1'b0}};
            center_coeff <= {`EFCB_CENTER_W{1'b0}};
            coeff_valid  <= 1'b0;
        end
    end
endmodule // efcb_bank

// ---- test/efcb_bank_checker.sv ----
// port assertions for the channel b coefficient bank
`timescale 1ns/10ps
module efcb_bank_checker #(
    parameter ADDR_W = 14
) (
    input wire              mclk,
    input wire              rstn,
    input wire [ADDR_W-1:0] avs_address,
    input wire              avs_read,
    input wire              avs_write,
    input wire [31:0]       avs_writedata,
    input wire [31:0]       avs_readdata,
    input wire              avs_waitrequest,
    input wire              dual_channel_mode,
    input wire [11:0]       tap0_coeff,
    input wire [17:0]       center_coeff,
    input wire              coeff_valid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_take;
        $rose(avs_read || avs_write);
    endsequence
    sequence s_wr_done(a);
        avs_write && !avs_waitrequest && avs_address == a && dual_channel_mode;
    endsequence
    chk_answer_time: assert property (s_take |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("answer not one cycle after take");
    chk_tap0_follow: assert property (s_wr_done(14'h1120) |=>
        tap0_coeff == $past(avs_writedata[11:0])) else $error("tap0 output wrong");
    chk_center_follow: assert property (s_wr_done(14'h1140) |=>
        center_coeff == $past(avs_writedata[17:0])) else $error("centre output wrong");
    chk_single_off: assert property (!dual_channel_mode |=>
        tap0_coeff == 12'h000 && center_coeff == 18'h00000 && !coeff_valid)
        else $error("taps live outside dual mode");
    chk_msb_read: assert property (avs_read && !avs_waitrequest |->
        !(avs_address == 14'h1120 && avs_readdata[11]) &&
        !(avs_address == 14'h1140 && avs_readdata[17])) else $error("field msb read back");
    chk_reset_zero: assert property ($rose(rstn) |->
        tap0_coeff == 12'h000 && center_coeff == 18'h00000 && avs_waitrequest)
        else $error("outputs not cleared by reset");
endmodule // efcb_bank_checker

bind efcb_bank efcb_bank_checker #(.ADDR_W(ADDR_W)) u_chk (.mclk, .rstn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .dual_channel_mode, .tap0_coeff, .center_coeff, .coeff_valid);

// ---- test/efcb_bank_tb_top.sv ----
// self-checking bench for the channel b coefficient bank
`timescale 1ns/10ps
module efcb_bank_tb_top;
    logic        mclk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [13:0] avs_address = 14'h0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
    logic        dual_channel_mode = 1'b1, avs_waitrequest, coeff_valid;
    logic [11:0] tap0_coeff, tap1_coeff, tap2_coeff, tap3_coeff;
    logic [17:0] center_coeff;
    int          bad_count = 0, compares = 0;
    always #2.5 mclk = ~mclk;
    efcb_bank #(.ADDR_W(14)) i_dut (.mclk, .rstn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .dual_channel_mode, .tap0_coeff, .tap1_coeff, .tap2_coeff, .tap3_coeff,
        .center_coeff, .coeff_valid);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do
            @(posedge mclk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic t_access();
        logic [31:0] q;
        for (int i = 0; i < 5; i++)
        begin
            xfer(1'b0, 14'h1120 + 14'(i * 8), 32'h0, q);
            chk(q, 32'h0);
            xfer(1'b1, 14'h1120 + 14'(i * 8), 32'hFFFFF8F0 | 32'(i), q);
        end
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b0, 14'h1120 + 14'(i * 8), 32'h0, q);
            chk(q, 32'h0000F0F0 | 32'(i));
        end
        xfer(1'b0, 14'h1140, 32'h0, q);
        chk(q, 32'h00FDF8F4);
        xfer(1'b0, 14'h1124, 32'h0, q);
        chk(q, 32'h0);
        chk({tap0_coeff, tap1_coeff}, 32'h008F08F1);
        chk({tap2_coeff, tap3_coeff}, 32'h008F28F3);
        chk(center_coeff, 32'h0003F8F4);
        $display("access test done");
    endtask
    task automatic t_mode();
        logic [31:0] q;
        @(posedge mclk);
        dual_channel_mode <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk({coeff_valid, tap3_coeff, center_coeff}, 32'h0);
        xfer(1'b0, 14'h1138, 32'h0, q);
        chk(q, 32'h0000F0F3);
        xfer(1'b0, 14'h1180, 32'h0, q);
        chk(q, 32'h0);
        dual_channel_mode <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk({coeff_valid, tap3_coeff, center_coeff}, 32'h63CFF8F4);
        xfer(1'b0, 14'h1180, 32'h0, q);
        chk(q, 32'h3);
        $display("mode test done");
    endtask
    task automatic t_reset();
        logic [31:0] q;
        @(posedge mclk);
        rstn <= 1'b0;
        @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        chk({avs_waitrequest, coeff_valid, tap0_coeff, center_coeff}, 32'h80000000);
        chk(avs_readdata, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            xfer(1'b0, 14'h1120 + 14'(i * 8), 32'h0, q);
            chk(q, 32'h0);
        end
        $display("reset test done");
    endtask
    task automatic t_lanes();
        logic [31:0] q;
        avs_byteenable <= 4'h1;
        xfer(1'b1, 14'h1128, 32'hFFFFFFAB, q);
        avs_byteenable <= 4'h2;
        xfer(1'b1, 14'h1128, 32'hFFFFFCFF, q);
        avs_byteenable <= 4'hC;
        xfer(1'b1, 14'h1130, 32'h12345678, q);
        avs_byteenable <= 4'hF;
        xfer(1'b0, 14'h1128, 32'h0, q);
        chk(q, 32'h0000F4AB);
        xfer(1'b0, 14'h1130, 32'h0, q);
        chk(q, 32'h0);
        chk({tap1_coeff, tap2_coeff}, 32'h00CAB000);
        $display("lane test done");
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        t_access();
        t_mode();
        t_reset();
        t_lanes();
        conclude();
    end
    initial
    begin
        #20000;
        bad_count++;
        conclude();
    end
endmodule // efcb_bank_tb_top
